// >>> src/srot_pkg.sv
// shared constants and types for the shift and rotate unit
package srot_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam int         ADDR_W     = 8;
   localparam logic [7:0] OFF_DEST   = 8'h00;
   localparam logic [7:0] OFF_SRC    = 8'h04;
   localparam logic [7:0] OFF_CTRL   = 8'h08;
   localparam logic [7:0] OFF_FLAGS  = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_COUNT  = 8'h14;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operand sizes
   localparam logic [1:0] SZ_BYTE  = 2'h0;
   localparam logic [1:0] SZ_WORD  = 2'h1;
   localparam logic [1:0] SZ_DWORD = 2'h2;

   localparam logic [31:0] MASK_BYTE  = 32'h0000_00FF;
   localparam logic [31:0] MASK_WORD  = 32'h0000_FFFF;
   localparam logic [31:0] MASK_DWORD = 32'hFFFF_FFFF;
   localparam logic [31:0] TOP_BYTE   = 32'h0000_0080;
   localparam logic [31:0] TOP_WORD   = 32'h0000_8000;
   localparam logic [31:0] TOP_DWORD  = 32'h8000_0000;

   // count sources
   localparam logic [1:0] CS_ONE = 2'h0;
   localparam logic [1:0] CS_IMM = 2'h1;
   localparam logic [1:0] CS_REG = 2'h2;

   localparam int         CNT_W    = 5;
   localparam int         CNT_MAX  = 31;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE  = 5'h01;

   typedef enum logic [3:0] {
      OPC_SHL,
      OPC_SHR,
      OPC_SAR,
      OPC_DOUBLE_LEFT_SHIFT,
      OPC_DOUBLE_RIGHT_SHIFT,
      OPC_ROL,
      OPC_ROR,
      OPC_RCL,
      OPC_RCR
   } srot_op_e;

   localparam logic [3:0] OP_COUNT = 4'h9;

   // control register, low 20 bits used
   typedef struct packed {
      logic [11:0] rsv;
      logic [7:0]  imm;
      logic [1:0]  rsv2;
      logic [1:0]  cnt_src;
      logic [1:0]  size;
      logic [1:0]  rsv1;
      logic [3:0]  op;
   } srot_ctrl_s;

   // flag register, low 6 bits used
   typedef struct packed {
      logic [25:0] rsv;
      logic        overflow_flag;
      logic        sign_flag;
      logic        zero_flag;
      logic        aux_carry_flag;
      logic        parity_flag;
      logic        carry_flag;
   } srot_flags_s;

   localparam logic [31:0] CTRL_WMASK  = 32'h000F_F3CF;
   localparam logic [31:0] FLAGS_WMASK = 32'h0000_003F;

endpackage : srot_pkg

// >>> src/srot_unit.sv
// shift and rotate datapath unit behind an AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

module srot_unit import srot_pkg::*; (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // write address channel
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // write data channel
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // write response channel
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // read address channel
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // read data channel
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic [31:0]       dest;
   logic [31:0]       src;
   logic [31:0]       count_register;
   logic [31:0]       result;
   srot_ctrl_s        ctrl;
   srot_flags_s       flags;
   logic              exec;

   // byte lane mask from strobes
   logic [31:0] strb_mask;
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign strb_mask[8*g +: 8] = {8{w_strb_q[g]}};
   end

   // write decode
   wire wr_fire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire wr_dest   = wr_fire && (aw_addr_q == OFF_DEST);
   wire wr_src    = wr_fire && (aw_addr_q == OFF_SRC);
   wire wr_ctrl   = wr_fire && (aw_addr_q == OFF_CTRL);
   wire wr_flags  = wr_fire && (aw_addr_q == OFF_FLAGS);
   wire wr_count  = wr_fire && (aw_addr_q == OFF_COUNT);
   wire wr_known  = wr_dest | wr_src | wr_ctrl | wr_flags | wr_count;
   wire [31:0] wr_bits = w_data_q & strb_mask;

   // read decode
   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire rd_known = (s_axi_araddr == OFF_DEST) || (s_axi_araddr == OFF_SRC)
                || (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_FLAGS)
                || (s_axi_araddr == OFF_RESULT) || (s_axi_araddr == OFF_COUNT);
   wire [31:0] rd_val =
        (s_axi_araddr == OFF_DEST)   ? dest :
        (s_axi_araddr == OFF_SRC)    ? src :
        (s_axi_araddr == OFF_CTRL)   ? 32'(ctrl) :
        (s_axi_araddr == OFF_FLAGS)  ? 32'(flags) :
        (s_axi_araddr == OFF_RESULT) ? result :
        (s_axi_araddr == OFF_COUNT)  ? count_register : 32'h0000_0000;

   // operand width selection
   wire [31:0] size_mask = (ctrl.size == SZ_BYTE) ? MASK_BYTE :
                           (ctrl.size == SZ_WORD) ? MASK_WORD : MASK_DWORD;
   wire [31:0] size_top  = (ctrl.size == SZ_BYTE) ? TOP_BYTE :
                           (ctrl.size == SZ_WORD) ? TOP_WORD : TOP_DWORD;

   // effective count, five bits for every op
   wire [CNT_W-1:0] eff_cnt = (ctrl.cnt_src == CS_ONE) ? CNT_ONE :
                              (ctrl.cnt_src == CS_REG) ? count_register[CNT_W-1:0] :
                                                         ctrl.imm[CNT_W-1:0];

   wire srot_op_e op     = srot_op_e'(ctrl.op);
   wire           op_ok  = ctrl.op < OP_COUNT;
   wire           is_rot = (op == OPC_ROL) || (op == OPC_ROR)
                        || (op == OPC_RCL) || (op == OPC_RCR);

   // bit-serial model unrolled over the count
   logic [31:0] step_res;
   logic        step_carry;
   always_comb begin
      logic [31:0] r;
      logic [31:0] s;
      logic        c;
      logic        hi;
      r = dest & size_mask;
      s = src & size_mask;
      c = flags.carry_flag;
      hi = 1'b0;
      for (int i = 0; i < CNT_MAX; i++) begin
         if (i < int'(eff_cnt)) begin
            hi = |(r & size_top);
            case (op)
               OPC_SHL: begin
                  c = hi;
                  r = (r << 1) & size_mask;
               end
               OPC_SHR: begin
                  c = r[0];
                  r = r >> 1;
               end
               OPC_SAR: begin
                  c = r[0];
                  r = (r >> 1) | (r & size_top);
               end
               OPC_DOUBLE_LEFT_SHIFT: begin
                  c = hi;
                  r = ((r << 1) | {31'h0000_0000, |(s & size_top)}) & size_mask;
                  s = (s << 1) & size_mask;
               end
               OPC_DOUBLE_RIGHT_SHIFT: begin
                  c = r[0];
                  r = (r >> 1) | (s[0] ? size_top : 32'h0000_0000);
                  s = s >> 1;
               end
               OPC_ROL: begin
                  c = hi;
                  r = ((r << 1) | {31'h0000_0000, hi}) & size_mask;
               end
               OPC_ROR: begin
                  c = r[0];
                  r = (r >> 1) | (r[0] ? size_top : 32'h0000_0000);
               end
               OPC_RCL: begin
                  r = ((r << 1) | {31'h0000_0000, c}) & size_mask;
                  c = hi;
               end
               OPC_RCR: begin
                  hi = r[0];
                  r = (r >> 1) | (c ? size_top : 32'h0000_0000);
                  c = hi;
               end
               default: begin
                  r = r;
               end
            endcase
         end
      end
      step_res   = r;
      step_carry = c;
   end

   wire res_msb  = |(step_res & size_top);
   wire dest_msb = |(dest & size_top);

   // flag update; undefined flags simply keep their value
   srot_flags_s next_flags;
   always_comb begin
      next_flags = flags;
      if (op_ok && (eff_cnt != CNT_ZERO)) begin
         next_flags.carry_flag = step_carry;
         if (eff_cnt == CNT_ONE) begin
            next_flags.overflow_flag = res_msb ^ dest_msb;
         end
         if (!is_rot) begin
            next_flags.sign_flag   = res_msb;
            next_flags.zero_flag   = (step_res == 32'h0000_0000);
            next_flags.parity_flag = ~^step_res[7:0];
         end
      end
   end

   // zero count or bad op returns destination masked to the operand size
   wire [31:0] next_result = (op_ok && (eff_cnt != CNT_ZERO)) ? step_res
                                                             : (dest & size_mask);

   // write channels, either order
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr_q     <= '0;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_q     <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read channel
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // register file and execution; source is never written by an op
   always_ff @(posedge clk) begin
      if (rst) begin
         dest           <= 32'h0000_0000;
         src            <= 32'h0000_0000;
         count_register <= 32'h0000_0000;
         ctrl           <= '0;
         flags          <= '0;
         result         <= 32'h0000_0000;
         exec           <= 1'b0;
      end else begin
         exec <= wr_ctrl;
         if (wr_dest) dest <= (dest & ~strb_mask) | wr_bits;
         if (wr_src) src <= (src & ~strb_mask) | wr_bits;
         if (wr_count) count_register <= (count_register & ~strb_mask) | wr_bits;
         if (wr_ctrl) ctrl <= (ctrl & ~(strb_mask & CTRL_WMASK)) | (wr_bits & CTRL_WMASK);
         if (wr_flags) begin
            flags <= (flags & ~(strb_mask & FLAGS_WMASK)) | (wr_bits & FLAGS_WMASK);
         end else if (exec) begin
            flags <= next_flags;
         end
         if (exec) result <= next_result;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire dw = ctrl.size == SZ_DWORD;
   wire nz = eff_cnt != CNT_ZERO;

   property p_zero_cnt;
      exec && !nz |=> $stable(flags) && result == $past(dest & size_mask);
   endproperty
   a_zero_cnt: assert property (p_zero_cnt) else $error("zero count altered state");

   property p_sar_fill;
      exec && dw && op == OPC_SAR |=> result == 32'($signed($past(dest)) >>> $past(eff_cnt));
   endproperty
   a_sar_fill: assert property (p_sar_fill) else $error("arith right fill wrong");

   property p_shr_cnt_reg;
      exec && dw && op == OPC_SHR && ctrl.cnt_src == CS_REG
      |=> result == ($past(dest) >> $past(count_register[4:0]));
   endproperty
   a_shr_cnt_reg: assert property (p_shr_cnt_reg) else $error("count register masking wrong");

   property p_shl_carry;
      exec && dw && op == OPC_SHL && nz
      |=> result == ($past(dest) << $past(eff_cnt))
          && flags.carry_flag == $past(dest[32 - int'(eff_cnt)]);
   endproperty
   a_shl_carry: assert property (p_shl_carry) else $error("left shift or carry wrong");

   property p_of_one;
      exec && dw && eff_cnt == CNT_ONE && op_ok
      |=> flags.overflow_flag == (result[31] ^ $past(dest[31]));
   endproperty
   a_of_one: assert property (p_of_one) else $error("one-bit overflow wrong");

   property p_szp;
      exec && nz && op_ok && !is_rot
      |=> flags.zero_flag == (result == 32'h0000_0000) && flags.parity_flag == ~^result[7:0];
   endproperty
   a_szp: assert property (p_szp) else $error("zero or parity flag wrong");

   property p_rot_keep;
      exec && is_rot |=> flags.sign_flag == $past(flags.sign_flag)
         && flags.zero_flag == $past(flags.zero_flag)
         && flags.parity_flag == $past(flags.parity_flag)
         && flags.aux_carry_flag == $past(flags.aux_carry_flag);
   endproperty
   a_rot_keep: assert property (p_rot_keep) else $error("rotate touched other flags");

   property p_rol;
      exec && dw && op == OPC_ROL
      |=> result == 32'(({$past(dest), $past(dest)} << $past(eff_cnt)) >> 32);
   endproperty
   a_rol: assert property (p_rol) else $error("rotate left wrong");

   property p_rcl_one;
      exec && dw && op == OPC_RCL && eff_cnt == CNT_ONE
      |=> result == {$past(dest[30:0]), $past(flags.carry_flag)}
          && flags.carry_flag == $past(dest[31]);
   endproperty
   a_rcl_one: assert property (p_rcl_one) else $error("rotate through carry wrong");

   property p_double_left_shift;
      exec && dw && op == OPC_DOUBLE_LEFT_SHIFT && nz
      |=> result == 32'(({$past(dest), $past(src)} << $past(eff_cnt)) >> 32) && $stable(src);
   endproperty
   a_double_left_shift: assert property (p_double_left_shift) else $error("double left shift wrong");

   property p_double_right_shift;
      exec && dw && op == OPC_DOUBLE_RIGHT_SHIFT && nz
      |=> result == 32'({$past(src), $past(dest)} >> $past(eff_cnt)) && $stable(src);
   endproperty
   a_double_right_shift: assert property (p_double_right_shift) else $error("double right shift wrong");

   property p_ror;
      exec && dw && op == OPC_ROR
      |=> result == 32'({$past(dest), $past(dest)} >> $past(eff_cnt));
   endproperty
   a_ror: assert property (p_ror) else $error("rotate right wrong");

   property p_rcr_one;
      exec && dw && op == OPC_RCR && eff_cnt == CNT_ONE
      |=> result == {$past(flags.carry_flag), $past(dest[31:1])}
          && flags.carry_flag == $past(dest[0]);
   endproperty
   a_rcr_one: assert property (p_rcr_one) else $error("carry rotate right wrong");

   property p_src_keep;
      exec |=> $stable(src);
   endproperty
   a_src_keep: assert property (p_src_keep) else $error("source changed by op");

   property p_rd_answer;
      rd_fire |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

   property p_wr_answer;
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");

   c_sar: cover property (exec && op == OPC_SAR && dest[31] && nz);
   c_double_right_shift: cover property (exec && op == OPC_DOUBLE_RIGHT_SHIFT && ctrl.size == SZ_WORD);
   c_rcr: cover property (exec && op == OPC_RCR && ctrl.size == SZ_BYTE);
   c_zero: cover property (exec && !nz);
   c_double_left_shift_dw: cover property (exec && op == OPC_DOUBLE_LEFT_SHIFT && dw);

endmodule : srot_unit

// >>> verification/srot_axi_master.sv
// register bus master model standing in for the decode and register file side
`timescale 1ns/10ps

module srot_axi_master import srot_pkg::*; (
   // clock
   input  wire logic              clk,
   // write channels
   output logic [ADDR_W-1:0]      awaddr,
   output logic                   awvalid,
   input  wire logic              awready,
   output logic [31:0]            wdata,
   output logic [3:0]             wstrb,
   output logic                   wvalid,
   input  wire logic              wready,
   input  wire logic [1:0]        bresp,
   input  wire logic              bvalid,
   output logic                   bready,
   // read channels
   output logic [ADDR_W-1:0]      araddr,
   output logic                   arvalid,
   input  wire logic              arready,
   input  wire logic [31:0]       rdata,
   input  wire logic [1:0]        rresp,
   input  wire logic              rvalid,
   output logic                   rready
);
   localparam int LIMIT = 64;
   logic          hung;

   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      hung = 1'b0;
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int n;
      r = 2'bxx;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < LIMIT; n++) begin
         @(posedge clk);
         // released address and data lines must not keep showing the old value
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr  <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata  <= ~d;
         end
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == LIMIT) hung = 1'b1;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      d = 'x;
      r = 2'bxx;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < LIMIT; n++) begin
         @(posedge clk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr  <= ~a;
         end
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == LIMIT) hung = 1'b1;
   endtask : rd

endmodule : srot_axi_master

// >>> verification/srot_unit_tb.sv
// self-checking bench for the shift and rotate unit
`timescale 1ns/10ps

module srot_unit_tb import srot_pkg::*;;
   typedef struct {
      srot_op_e    op;
      logic [1:0]  sz;
      logic [1:0]  cs;
      logic [7:0]  cnt;
      logic [31:0] d;
      logic [31:0] s;
      logic [31:0] f;
      logic [31:0] res;
      logic [31:0] ef;
   } srot_row_s;

   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, last_res;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   int                n_errors = 0;
   int                n_compared = 0;
   int                cyc = 0;
   logic [ADDR_W-1:0] offs [6] = '{OFF_DEST, OFF_SRC, OFF_CTRL, OFF_FLAGS, OFF_RESULT, OFF_COUNT};
   srot_row_s         rows [] = '{
      '{OPC_SHL,  SZ_BYTE,  CS_REG, 8'hE3, 32'h81, 32'h0, 32'h0, 32'h08, 32'h00},
      '{OPC_SHL,  SZ_DWORD, CS_ONE, 8'h0, 32'h4000_0001, 32'h0, 32'h0, 32'h8000_0002, 32'h30},
      '{OPC_SHR,  SZ_WORD,  CS_IMM, 8'h3, 32'h8005, 32'h0, 32'h3F, 32'h1000, 32'h27},
      '{OPC_SAR,  SZ_BYTE,  CS_REG, 8'h2, 32'hF7, 32'h0, 32'h0, 32'hFD, 32'h11},
      '{OPC_SAR,  SZ_DWORD, CS_ONE, 8'h0, 32'h8000_0001, 32'h0, 32'h20, 32'hC000_0000, 32'h13},
      '{OPC_SHL,  SZ_WORD,  CS_REG, 8'h0, 32'h1234, 32'h0, 32'h3F, 32'h1234, 32'h3F},
      '{OPC_DOUBLE_LEFT_SHIFT, SZ_WORD,  CS_REG, 8'h4, 32'h1234, 32'hABCD, 32'h0, 32'h234A, 32'h1},
      '{OPC_DOUBLE_RIGHT_SHIFT, SZ_DWORD, CS_REG, 8'h8, 32'h1234_5678, 32'hAB, 32'h0, 32'hAB12_3456, 32'h12},
      '{OPC_DOUBLE_LEFT_SHIFT, SZ_DWORD, CS_ONE, 8'h0, 32'h7FFF_FFFF, 32'h8000_0000, 32'h0,
        32'hFFFF_FFFF, 32'h32},
      '{OPC_DOUBLE_RIGHT_SHIFT, SZ_WORD,  CS_REG, 8'h40, 32'h1234, 32'h5678, 32'h15,
        32'h1234, 32'h15},
      '{OPC_ROL,  SZ_BYTE,  CS_REG, 8'h1F, 32'h81, 32'h0, 32'h1E, 32'hC0, 32'h1E},
      '{OPC_ROR,  SZ_DWORD, CS_ONE, 8'h0, 32'h1, 32'h0, 32'h1E, 32'h8000_0000, 32'h3F},
      '{OPC_RCL,  SZ_WORD,  CS_REG, 8'h11, 32'h8001, 32'h0, 32'h1, 32'h8001, 32'h1},
      '{OPC_RCL,  SZ_DWORD, CS_ONE, 8'h0, 32'h8000_0001, 32'h0, 32'h0, 32'h2, 32'h21},
      '{OPC_RCR,  SZ_BYTE,  CS_IMM, 8'h5, 32'h2, 32'h0, 32'h1, 32'h28, 32'h0},
      '{OPC_ROL,  SZ_DWORD, CS_REG, 8'h20, 32'h1234, 32'h0, 32'h2A, 32'h1234, 32'h2A},
      '{OPC_RCR,  SZ_DWORD, CS_ONE, 8'h0, 32'h8000_0000, 32'h0, 32'h0, 32'h4000_0000, 32'h20}
   };

   always #5 clk = ~clk;

   srot_unit srot_unit_i (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   srot_axi_master srot_axi_master_i (
      .clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [1:0] rs;
      srot_axi_master_i.wr(a, d, 4'hF, rs);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
   endtask : wreg

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  rs;
      srot_axi_master_i.rd(a, d, rs);
      check(d, e);
      check({30'h0, rs}, {30'h0, er});
   endtask : rchk

   task automatic run(input srot_row_s t);
      srot_ctrl_s  c;
      last_res = t.res;
      c = '0;
      c.op = t.op;
      c.size = t.sz;
      c.cnt_src = t.cs;
      c.imm = t.cnt;
      wreg(OFF_DEST, t.d);
      wreg(OFF_SRC, t.s);
      wreg(OFF_COUNT, {24'h0, t.cnt});
      wreg(OFF_FLAGS, t.f);
      wreg(OFF_CTRL, c[31:0]);
      repeat (2) @(posedge clk);
      rchk(OFF_RESULT, t.res, RESP_OKAY);
      rchk(OFF_RESULT, t.res, RESP_OKAY);
      rchk(OFF_FLAGS, t.ef, RESP_OKAY);
      rchk(OFF_FLAGS, t.ef, RESP_OKAY);
      rchk(OFF_SRC, t.s, RESP_OKAY);
   endtask : run

   task automatic stop_test();
      $display("n_errors %0d n_compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (srot_axi_master_i.hung === 1'b1 || cyc > 20000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) rchk(offs[i], 32'h0, RESP_OKAY);
      foreach (rows[i]) run(rows[i]);
      // unmapped read and a refused write to the read-only result
      rchk(8'h18, 32'h0, RESP_SLVERR);
      srot_axi_master_i.wr(OFF_RESULT, 32'hDEAD_BEEF, 4'hF, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      rchk(OFF_RESULT, last_res, RESP_OKAY);
      // byte enables on a partial write
      wreg(OFF_DEST, 32'hFFFF_FFFF);
      srot_axi_master_i.wr(OFF_DEST, 32'h0, 4'h1, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      rchk(OFF_DEST, 32'hFFFF_FF00, RESP_OKAY);
      // second reset in mid-run clears the registers
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) rchk(offs[i], 32'h0, RESP_OKAY);
      stop_test();
   end

endmodule : srot_unit_tb
